// [shared/adv_cfg.svh]
`ifndef ADV_CFG_SVH
`define ADV_CFG_SVH

// ====================================================================
// timing
`define ADV_CLK_MHZ      40
`define ADV_WINDOW_US    40
`define ADV_WINDOW_CYC   (`ADV_WINDOW_US * `ADV_CLK_MHZ)
`define ADV_CNT_W        11

// ====================================================================
// register byte offsets
`define ADV_OFS_CTRL     12'h000
`define ADV_OFS_THRESH   12'h004
`define ADV_OFS_STATUS   12'h008

// ====================================================================
// control register fields
`define ADV_CTRL_TX_EN   0
`define ADV_CTRL_RX_EN   1
`define ADV_CTRL_EVEN_EN 2
`define ADV_CTRL_ODD_LO  4
`define ADV_CTRL_EVEN_LO 6
`define ADV_CTRL_W       8
`define ADV_CTRL_RST     8'h00

// ====================================================================
// threshold register
`define ADV_THR_W        8
`define ADV_THR_RST      8'h00

// ====================================================================
// pin routing
`define ADV_PINS         3

`endif

// [shared/adv_pkg.sv]
package adv_pkg;
  `include "adv_cfg.svh"

  // ==================================================================
  // register decode result
  typedef enum logic [1:0] {
    ADV_REG_CTRL,
    ADV_REG_THRESH,
    ADV_REG_STATUS,
    ADV_REG_NONE
  } adv_reg_t;

  // ==================================================================
  // whole state of the controller
  typedef struct packed {
    logic [`ADV_CTRL_W-1:0] ctrl;        // enables and pin routing
    logic [`ADV_THR_W-1:0]  thresh;      // energy threshold
    logic                   retry_odd;   // parity of retry count
    logic                   rx_flip;     // receive-side toggle state
    logic                   pending;     // postponed toggle
    logic [`ADV_CNT_W-1:0]  sample_cnt;  // energy sample period
    logic [`ADV_CNT_W-1:0]  pre_cnt;     // preamble recency window
    logic [`ADV_PINS-1:0]   odd_val;     // primary select pin values
    logic [`ADV_PINS-1:0]   odd_oe;      // primary select enables
    logic [`ADV_PINS-1:0]   even_val;    // secondary select pin values
    logic [`ADV_PINS-1:0]   even_oe;     // secondary select enables
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } adv_state_t;
endpackage

// [core/adv_top.sv]
// Summary of operation
// - unacknowledged frame retries on other antenna
// - receive diversity optional, enabled by software
// - sample channel energy every 40 us
// - toggle antenna when energy below threshold
// - postpone toggle during ack wait, reception
// - toggle only after recent good preamble
// - both modes share one select pair
// - primary select high on odd retries xor receive toggle
// - optional inverted secondary select, pin routed
`timescale 1ns/1ps
`include "adv_cfg.svh"

module adv_top (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  // apb slave
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [11:0]                  paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic                              pready_out,
  output logic                              pslverr_out,
  output logic [31:0]                       prdata_out,
  // radio sequencer and modem status
  input  wire logic                         tx_frame_start_in,
  input  wire logic                         tx_retry_in,
  input  wire logic                         rx_listen_in,
  input  wire logic                         ack_wait_in,
  input  wire logic                         rx_busy_in,
  input  wire logic                         preamble_good_in,
  input  wire logic [`ADV_THR_W-1:0]        energy_in,
  // antenna_select_odd pins (switch_control_a)
  output logic [`ADV_PINS-1:0]              antenna_select_odd_out,
  output logic [`ADV_PINS-1:0]              antenna_select_odd_oe_out,
  // antenna_select_even pins (switch_control_b)
  output logic [`ADV_PINS-1:0]              antenna_select_even_out,
  output logic [`ADV_PINS-1:0]              antenna_select_even_oe_out
);
  import adv_pkg::*;

  // ==================================================================
  // constants and state
  localparam logic [`ADV_CNT_W-1:0] WIN_LAST = `ADV_CNT_W'(`ADV_WINDOW_CYC - 1);
  localparam logic [`ADV_CNT_W-1:0] WIN_FULL = `ADV_CNT_W'(`ADV_WINDOW_CYC);

  adv_state_t state;        // registered state
  adv_state_t next_state;   // next value

  // ==================================================================
  // address decode, shared by read and write paths
  function automatic adv_reg_t adv_decode(input logic [11:0] addr);
    unique case (addr)
      `ADV_OFS_CTRL:   adv_decode = ADV_REG_CTRL;
      `ADV_OFS_THRESH: adv_decode = ADV_REG_THRESH;
      `ADV_OFS_STATUS: adv_decode = ADV_REG_STATUS;
      default:         adv_decode = ADV_REG_NONE;
    endcase
  endfunction

  // ==================================================================
  // decoded helpers
  logic       tx_en;          // transmit diversity on
  logic       rx_en;          // receive diversity on
  logic       even_en;        // secondary select enabled
  logic [1:0] odd_route;      // primary select pin choice
  logic [1:0] even_route;     // secondary select pin choice
  logic       rx_active;      // receive diversity running now
  logic       tick;           // energy sample instant
  logic       pre_recent;     // preamble seen in window
  logic       want_toggle;    // low energy, toggle wanted
  logic       hold;           // activity forbids a toggle
  logic       antenna;        // combined select level
  logic       setup;          // apb setup phase
  logic       access;         // apb completing access
  adv_reg_t   sel_reg;        // decoded register

  assign tx_en      = state.ctrl[`ADV_CTRL_TX_EN];
  assign rx_en      = state.ctrl[`ADV_CTRL_RX_EN];
  assign even_en    = state.ctrl[`ADV_CTRL_EVEN_EN];
  assign odd_route  = state.ctrl[`ADV_CTRL_ODD_LO +: 2];
  assign even_route = state.ctrl[`ADV_CTRL_EVEN_LO +: 2];
  assign rx_active  = rx_en && rx_listen_in;
  assign tick       = rx_active && (state.sample_cnt == '0);
  assign pre_recent = (state.pre_cnt != '0);
  assign want_toggle = tick && (energy_in < state.thresh) && pre_recent;
  assign hold       = ack_wait_in || rx_busy_in;
  assign setup      = psel_in && !penable_in;
  assign access     = psel_in && penable_in && state.pready;
  assign sel_reg    = adv_decode(paddr_in);

  // ==================================================================
  // next-state logic
  always_comb begin
    next_state = state;
    // apb handshake: one cycle after setup, ready for one cycle
    next_state.pready  = setup;
    next_state.pslverr = setup && (sel_reg == ADV_REG_NONE);
    if (setup && !pwrite_in) begin
      unique case (sel_reg)
        ADV_REG_CTRL:   next_state.prdata = {24'h000000, state.ctrl};
        ADV_REG_THRESH: next_state.prdata = {24'h000000, state.thresh};
        ADV_REG_STATUS: next_state.prdata = {27'h0000000, pre_recent, state.pending,
                                             state.rx_flip, state.retry_odd, antenna};
        default:        next_state.prdata = 32'h00000000;
      endcase
    end
    // register writes take effect at the completing edge
    if (access && pwrite_in) begin
      unique case (sel_reg)
        ADV_REG_CTRL:   next_state.ctrl   = pwdata_in[`ADV_CTRL_W-1:0];
        ADV_REG_THRESH: next_state.thresh = pwdata_in[`ADV_THR_W-1:0];
        default:        ;
      endcase
    end
    // sample period counter, reloaded while idle
    if (!rx_active || tick) begin
      next_state.sample_cnt = WIN_LAST;
    end else begin
      next_state.sample_cnt = state.sample_cnt - `ADV_CNT_W'(1);
    end
    // preamble recency window
    if (preamble_good_in) begin
      next_state.pre_cnt = WIN_FULL;
    end else if (pre_recent) begin
      next_state.pre_cnt = state.pre_cnt - `ADV_CNT_W'(1);
    end
    // transmit side: flip on each unacknowledged retry
    if (tx_en && tx_retry_in) begin
      next_state.retry_odd = !state.retry_odd;
    end
    // receive side: toggle now, or postpone past activity
    if (!rx_en) begin
      next_state.pending = 1'b0;
    end else if (hold) begin
      if (want_toggle) begin
        next_state.pending = 1'b1;
      end
    end else if (want_toggle || state.pending) begin
      next_state.rx_flip = !state.rx_flip;
      next_state.pending = 1'b0;
    end
    // new frame restarts on the primary antenna
    if (tx_frame_start_in) begin
      next_state.retry_odd = 1'b0;
      next_state.rx_flip   = 1'b0;
      next_state.pending   = 1'b0;
    end
    // pin routing of the shared select pair
    for (int i = 0; i < `ADV_PINS; i++) begin
      next_state.odd_oe[i]   = (odd_route == 2'(i));
      next_state.even_oe[i]  = even_en && (even_route == 2'(i));
      next_state.odd_val[i]  = next_state.odd_oe[i] &&
                               (next_state.retry_odd ^ next_state.rx_flip);
      next_state.even_val[i] = next_state.even_oe[i] &&
                               !(next_state.retry_odd ^ next_state.rx_flip);
    end
  end

  // combined select level of the current state
  assign antenna = state.retry_odd ^ state.rx_flip;

  // ==================================================================
  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state            <= '0;
      state.ctrl       <= `ADV_CTRL_RST;
      state.thresh     <= `ADV_THR_RST;
      state.sample_cnt <= WIN_LAST;
      state.odd_oe     <= `ADV_PINS'(1);
    end else begin
      state <= next_state;
    end
  end

  // ==================================================================
  // outputs straight from the state register
  assign pready_out                 = state.pready;
  assign pslverr_out                = state.pslverr;
  assign prdata_out                 = state.prdata;
  assign antenna_select_odd_out     = state.odd_val;
  assign antenna_select_odd_oe_out  = state.odd_oe;
  assign antenna_select_even_out    = state.even_val;
  assign antenna_select_even_oe_out = state.even_oe;

  // ==================================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_frame_restart: assert property (
    tx_frame_start_in |=> !state.retry_odd && !state.rx_flip)
    else $error("frame did not restart on primary antenna");

  chk_retry_flip: assert property (
    tx_en && tx_retry_in && !tx_frame_start_in |=> state.retry_odd != $past(state.retry_odd))
    else $error("retry did not move to other antenna");

  chk_sample_count: assert property (
    rx_active && state.sample_cnt != '0 ##1 rx_active
      |-> state.sample_cnt == $past(state.sample_cnt) - `ADV_CNT_W'(1))
    else $error("energy sample counter skipped");

  chk_rx_disabled: assert property (
    !rx_en && !tx_frame_start_in |=> $stable(state.rx_flip))
    else $error("antenna toggled with receive diversity off");

  chk_high_energy: assert property (
    tick && energy_in >= state.thresh && !state.pending && !tx_frame_start_in
      |=> $stable(state.rx_flip))
    else $error("toggle with energy at or above threshold");

  chk_hold_busy: assert property (
    hold && !tx_frame_start_in |=> $stable(state.rx_flip))
    else $error("toggle during ack wait or reception");

  chk_pending_apply: assert property (
    rx_en && state.pending && !hold && !tx_frame_start_in
      |=> state.rx_flip != $past(state.rx_flip) && !state.pending)
    else $error("postponed toggle not applied");

  chk_no_preamble: assert property (
    tick && !pre_recent && !state.pending && !tx_frame_start_in |=> $stable(state.rx_flip))
    else $error("toggle without recent preamble");

  // level follows the combined select, drive enable follows last cycle's route
  chk_odd_level: assert property (
    1'b1 |=> (state.odd_val == (state.odd_oe & {`ADV_PINS{antenna}}))
      && (state.odd_oe == (`ADV_PINS'(1) << $past(odd_route))))
    else $error("primary select level or routing wrong");

  chk_even_inverse: assert property (
    even_en && even_route != 2'h3 ##1 1'b1
      |-> (state.even_val == (state.even_oe & {`ADV_PINS{!antenna}})) && (state.even_oe != '0))
    else $error("secondary select not inverse of primary");

  cov_retry_flip: cover property (tx_en && tx_retry_in ##1 antenna);
  cov_rx_toggle:  cover property (want_toggle && !hold ##1 state.rx_flip);
  cov_postponed:  cover property (state.pending ##[1:50] !state.pending);
endmodule

// [bench/adv_rf_switch.sv]
`timescale 1ns/1ps
`include "adv_cfg.svh"

// ==================================================================
// external two-way rf switch driven by both select lines
module adv_rf_switch (
  // select lines from the device
  input  wire logic [`ADV_PINS-1:0] ctl_a_in,
  input  wire logic [`ADV_PINS-1:0] ctl_a_oe_in,
  input  wire logic [`ADV_PINS-1:0] ctl_b_in,
  input  wire logic [`ADV_PINS-1:0] ctl_b_oe_in,
  // switch position
  output logic                      ant_out,
  output logic                      clash_out
);
  logic [`ADV_PINS-1:0] line_a;  // board lines, pulled low
  logic [`ADV_PINS-1:0] line_b;  // board lines, pulled low
  // an undriven line falls to its pull-down
  assign line_a    = ctl_a_in & ctl_a_oe_in;
  assign line_b    = ctl_b_in & ctl_b_oe_in;
  // position follows line a; line b must be its inverse when driven
  assign ant_out   = |line_a;
  assign clash_out = (|ctl_b_oe_in) && ((|line_b) == ant_out);
endmodule

// [bench/tb_antenna_diversity_control.sv]
`timescale 1ns/1ps
`include "adv_cfg.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp=%0h got=%0h", n, e, s); end end

module tb_antenna_diversity_control;
  // ================================================================
  // stimulus and observed signals
  logic        clk, rst, psel, pen, pwr, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        f_start, retry, listen, ack, busy, pre, e_hi, err;
  logic [7:0]  energy;
  logic [2:0]  odd, odd_oe, even, even_oe;
  logic        ant, clash;
  // reference model: retry parity and receive toggle
  int          par, tog, ko, ke, mismatches, checked;
  int          seed = 30;

  adv_top adv_top_i (.clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .tx_frame_start_in(f_start),
    .tx_retry_in(retry), .rx_listen_in(listen), .ack_wait_in(ack), .rx_busy_in(busy),
    .preamble_good_in(pre), .energy_in(energy), .antenna_select_odd_out(odd),
    .antenna_select_odd_oe_out(odd_oe), .antenna_select_even_out(even),
    .antenna_select_even_oe_out(even_oe));
  adv_rf_switch adv_rf_switch_i (.ctl_a_in(odd), .ctl_a_oe_in(odd_oe),
    .ctl_b_in(even), .ctl_b_oe_in(even_oe), .ant_out(ant), .clash_out(clash));

  // ================================================================
  // clock and random channel energy
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    energy <= e_hi ? (8'h80 | 8'($random(seed))) : (8'h7f & 8'($random(seed)));
  end

  // ================================================================
  // helpers
  task automatic end_sim;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // wait for pready with no cycle count assumed; a hang is left to the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // one-cycle pulse: 0 retry, 1 frame start, 2 preamble, 3 retry and start
  task automatic pulse(input int s);
    @(posedge clk);
    retry <= (s == 0 || s == 3);
    f_start <= (s == 1 || s == 3);
    pre <= (s == 2);
    @(posedge clk);
    retry <= 1'b0; f_start <= 1'b0; pre <= 1'b0;
  endtask
  // compare select pins with the model level
  task automatic pins;
    logic lvl;
    lvl = par[0] ^ tog[0];
    tick(3);
    `CHK("odd", {2'b00, lvl} << ko, odd)
    `CHK("even", {2'b00, ~lvl} << ke, even)
    `CHK("ant", lvl, ant)
    `CHK("clash", 1'b0, clash)
  endtask

  // ================================================================
  // main sequence
  initial begin
    rst = 1'b1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; f_start = 0;
    retry = 0; listen = 0; ack = 0; busy = 0; pre = 0; e_hi = 0; energy = 0;
    par = 0; tog = 0; mismatches = 0; checked = 0;
    tick(16);
    rst <= 1'b0;
    apb(0, `ADV_OFS_THRESH, 0);
    `CHK("thresh", 32'h0, rd)
    `CHK("oe_rst", 3'b001, odd_oe)
    apb(0, 12'h00c, 0);
    `CHK("slverr", 1'b1, err)
    for (int k = 0; k < 3; k++) begin
      apb(1, `ADV_OFS_CTRL, 32'(8'h05 | (k << 4) | ((2 - k) << 6)));
      tick(2);
      `CHK("odd_oe", 3'(1 << k), odd_oe)
      `CHK("even_oe", 3'(1 << (2 - k)), even_oe)
    end
    ko = 2;
    ke = 0;
    apb(1, `ADV_OFS_CTRL, 32'hf1);
    tick(2);
    `CHK("no_oe", 6'h0, {odd_oe, even_oe})
    apb(1, `ADV_OFS_CTRL, 32'h25);
    // software's retry limit for this frame: five attempts after the first
    for (int i = 0; i < 5; i++) begin
      pulse(0);
      par ^= 1;
      pins();
    end
    pulse(1);
    par = 0;
    pins();
    pulse(0);
    pulse(3);
    pins();
    apb(1, `ADV_OFS_CTRL, 32'h24);
    pulse(0);
    pins();
    apb(1, `ADV_OFS_THRESH, 32'h80);
    listen <= 1'b1;
    pulse(2);
    tick(1700);
    pins();
    apb(1, `ADV_OFS_CTRL, 32'h27);
    tick(800);
    pulse(2);
    tick(900);
    tog ^= 1;
    pins();
    tick(1600);
    pins();
    ack <= 1'b1;
    busy <= 1'b1;
    tick(600);
    pulse(2);
    tick(1000);
    pins();
    apb(0, `ADV_OFS_STATUS, 0);
    `CHK("pending", 1'b1, rd[3])
    ack <= 1'b0;
    pins();
    busy <= 1'b0;
    tog ^= 1;
    pins();
    e_hi <= 1'b1;
    tick(600);
    pulse(2);
    tick(1000);
    pins();
    // retry while receive diversity is also on: both act on one select pair
    pulse(0);
    par ^= 1;
    pins();
    end_sim();
  end

  // watchdog against a hung handshake
  initial begin
    tick(20000);
    mismatches++;
    end_sim();
  end
endmodule
